// File: logic/touch_defs.vh
// Constants for the resistive touch panel mode sequencer
`ifndef TOUCH_DEFS_VH
`define TOUCH_DEFS_VH
// ********************
// Register map
// ********************
`define TOUCH_MODE_SELECT_ADDR 8'h08
`define CONVERTER_CONFIG_ADDR 8'h09
`define TOUCH_MODE_RESET 8'h07
`define CONVERTER_CONFIG_RESET 8'h00
`define MODE_LSB 0
`define MODE_MSB 2
`define CFG_ADC_EN_BIT 0
`define CFG_REF_EN_BIT 1
`define CFG_IRQ_UNMASK_BIT 2
// ********************
// Mode codes
// ********************
`define MODE_X_POS 3'h0
`define MODE_Y_POS 3'h1
`define MODE_PRESSURE 3'h2
`define MODE_X_PLATE 3'h3
`define MODE_Y_PLATE 3'h4
`define MODE_STANDBY 3'h5
`define MODE_CONVERTER 3'h6
`define MODE_OFF 3'h7
// ********************
// Terminal connection codes
// ********************
`define CONN_OPEN 2'h0
`define CONN_REF 2'h1
`define CONN_GND 2'h2
`define CONN_ADC 2'h3
// ********************
// Timing
// ********************
`define CLK_PERIOD_PS 5000
`define DEGLITCH_MS 8
`define DEGLITCH_CYCLES ((`DEGLITCH_MS * 64'd1000000000) / `CLK_PERIOD_PS)
`define BREAK_NS 20
`define BREAK_CYCLES ((`BREAK_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`endif

// File: logic/touch_mode_sequencer.v
// Resistive touch panel mode sequencer with switch matrix control
// Function
// (R1) A state machine sequences the switch matrix through measure and standby modes.
// (R2) The three-bit mode field in touch_mode_select at 08h selects the state.
// (R3) Panel drive reference is off in standby and off modes.
// (R4) X position: x_plate_a to reference, x_plate_b to ground, Y plates to converter.
// (R5) Y position: y_plate_a to reference, y_plate_b to ground, X plates to converter.
// (R6) Pressure: both X plates to reference, both Y plates to ground.
// (R7) X plate: x_plate_a reference, x_plate_b ground, Y plates open.
// (R8) Y plate: X plates open, y_plate_a reference, y_plate_b ground, channel 14.
// (R9) Standby: sense both X plates, Y side pulled to ground.
// (R10) Panel reaches the converter only via gates on channels 14 and 15.
// (R11) Converter reference forced on when converter or touch interface is enabled.
// (R12) A reference enable bit keeps converter reference on while both are off.
// (R13) A 4-bit converter mux selects monitor channels and touch channels.
// (R14) Mode code 101 enters standby, where the block watches for touch.
// (R15) A touch held the 8 ms deglitch time raises interrupt when unmasked.
// (R16) Mode 111 opens all terminals, never detects touch nor interrupts; a flag set in standby keeps o_touch_irq up until config is read.
// (R17) Mode 110 gates all four terminals to the converter as standalone.
// (R18) New connections apply only after old drivers are released.
`include "touch_defs.vh"
module touch_mode_sequencer (
  input wire i_mclk,
  input wire i_rst,
  input wire i_ce,
  input wire i_wr_en,
  input wire i_rd_en,
  input wire [7:0] i_addr,
  input wire [7:0] i_wdata,
  input wire i_touch_sense,
  input wire [3:0] i_converter_select,
  output reg [7:0] o_rdata,
  output reg [1:0] o_x_plate_a,
  output reg [1:0] o_x_plate_b,
  output reg [1:0] o_y_plate_a,
  output reg [1:0] o_y_plate_b,
  output reg o_panel_drive_reference,
  output reg o_converter_reference,
  output reg o_panel_channel_a,
  output reg o_panel_channel_b,
  output reg [3:0] o_converter_mux,
  output reg o_touch_irq
);
  localparam ST_BREAK = 1'b0;
  localparam ST_APPLY = 1'b1;
  // ********************
  // Timing limits
  // ********************
  // Counts come from the shared header and are cut to counter width on purpose
  localparam [31:0] BREAK_LAST_FULL = `BREAK_CYCLES - 1;
  localparam [2:0] BREAK_LAST = BREAK_LAST_FULL[2:0];
  localparam [63:0] DEGLITCH_FULL = `DEGLITCH_CYCLES;
  localparam [31:0] DEGLITCH_TOP = DEGLITCH_FULL[31:0];
  localparam [31:0] DEGLITCH_LAST = DEGLITCH_TOP - 32'h1;
  reg [7:0] touch_mode_select;
  reg [7:0] converter_config;
  reg [2:0] active_mode;
  reg state;
  reg [2:0] break_cnt;
  reg [31:0] deglitch_cnt;
  reg touch_flag;
  reg [7:0] next_rdata;
  reg [7:0] conn;
  wire touch_sync;
  wire [2:0] req_mode;
  wire touch_on;

  assign req_mode = touch_mode_select[`MODE_MSB:`MODE_LSB];
  // Touch side counts as enabled from the write on, so the converter
  // reference does not dip while the matrix opens between two modes
  assign touch_on = (req_mode != `MODE_OFF) || (active_mode != `MODE_OFF);

  // Touch sense pin crosses into the clock domain
  touch_pin_sync u_touch_sync (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_ce(i_ce),
    .i_async(i_touch_sense),
    .o_sync(touch_sync)
  );

  // ********************
  // Register file
  // ********************
  // Writes land in the mode and configuration registers
  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      touch_mode_select <= `TOUCH_MODE_RESET;
      converter_config <= `CONVERTER_CONFIG_RESET;
    end else if (i_ce && i_wr_en) begin
      if (i_addr == `TOUCH_MODE_SELECT_ADDR) begin
        touch_mode_select <= {5'h00, i_wdata[2:0]}; // [R2]
      end else if (i_addr == `CONVERTER_CONFIG_ADDR) begin
        converter_config <= {5'h00, i_wdata[2:0]}; // [R12]
      end
    end
  end

  // Read data; bit 3 of config shows the sticky touch flag
  always @* begin
    next_rdata = 8'h00;
    if (i_addr == `TOUCH_MODE_SELECT_ADDR) begin
      next_rdata = touch_mode_select;
    end else if (i_addr == `CONVERTER_CONFIG_ADDR) begin
      next_rdata = {4'h0, touch_flag, converter_config[2:0]};
    end
  end

  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_rdata <= 8'h00;
    end else if (i_ce && i_rd_en) begin
      o_rdata <= next_rdata;
    end
  end

  // ********************
  // Mode sequencer
  // ********************
  // A mode change first opens every terminal, then applies the new mode
  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      state <= ST_APPLY;
      active_mode <= `MODE_OFF;
      break_cnt <= 3'h0;
    end else if (i_ce) begin
      case (state)
        ST_APPLY: begin
          if (req_mode != active_mode) begin // [R1]
            state <= ST_BREAK; // [R18]
            active_mode <= `MODE_OFF;
            break_cnt <= 3'h0;
          end
        end
        ST_BREAK: begin
          if (break_cnt >= BREAK_LAST) begin // [R18]
            state <= ST_APPLY;
            active_mode <= req_mode;
          end else begin
            break_cnt <= break_cnt + 3'h1;
          end
        end
        default: state <= ST_APPLY;
      endcase
    end
  end

  // Connection table per mode: x_a, x_b, y_a, y_b
  always @* begin
    conn = {`CONN_OPEN, `CONN_OPEN, `CONN_OPEN, `CONN_OPEN};
    case (active_mode)
      `MODE_X_POS: conn = {`CONN_REF, `CONN_GND, `CONN_ADC, `CONN_ADC}; // [R4]
      `MODE_Y_POS: conn = {`CONN_ADC, `CONN_ADC, `CONN_REF, `CONN_GND}; // [R5]
      `MODE_PRESSURE: conn = {`CONN_REF, `CONN_REF, `CONN_GND, `CONN_GND}; // [R6]
      `MODE_X_PLATE: conn = {`CONN_REF, `CONN_GND, `CONN_OPEN, `CONN_OPEN}; // [R7]
      `MODE_Y_PLATE: conn = {`CONN_OPEN, `CONN_OPEN, `CONN_REF, `CONN_GND}; // [R8]
      `MODE_STANDBY: conn = {`CONN_ADC, `CONN_ADC, `CONN_GND, `CONN_GND}; // [R9]
      `MODE_CONVERTER: conn = {`CONN_ADC, `CONN_ADC, `CONN_ADC, `CONN_ADC}; // [R17]
      default: conn = {`CONN_OPEN, `CONN_OPEN, `CONN_OPEN, `CONN_OPEN}; // [R16]
    endcase
  end

  // ********************
  // Switch matrix and reference outputs
  // ********************
  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_x_plate_a <= `CONN_OPEN;
      o_x_plate_b <= `CONN_OPEN;
      o_y_plate_a <= `CONN_OPEN;
      o_y_plate_b <= `CONN_OPEN;
      o_panel_drive_reference <= 1'b0;
      o_converter_reference <= 1'b0;
      o_panel_channel_a <= 1'b0;
      o_panel_channel_b <= 1'b0;
      o_converter_mux <= 4'h0;
    end else if (i_ce) begin
      o_x_plate_a <= conn[7:6];
      o_x_plate_b <= conn[5:4];
      o_y_plate_a <= conn[3:2];
      o_y_plate_b <= conn[1:0];
      // Reference off in standby, off and during break
      o_panel_drive_reference <= (active_mode != `MODE_STANDBY)
                                 && (active_mode != `MODE_OFF); // [R3]
      o_converter_reference <= converter_config[`CFG_ADC_EN_BIT] || touch_on // [R11]
                               || converter_config[`CFG_REF_EN_BIT]; // [R12]
      // Transfer gates close when a panel terminal routes to the converter; channel a also closes in X plate and Y plate modes
      o_panel_channel_a <= (conn[7:6] == `CONN_ADC) || (conn[3:2] == `CONN_ADC)
                           || (active_mode == `MODE_X_PLATE)
                           || (active_mode == `MODE_Y_PLATE); // [R10]
      o_panel_channel_b <= (conn[5:4] == `CONN_ADC) || (conn[1:0] == `CONN_ADC); // [R10]
      o_converter_mux <= i_converter_select; // [R13]
    end
  end

  // ********************
  // Touch detection
  // ********************
  // Touch must stay present the full deglitch time in standby
  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      deglitch_cnt <= 32'h0;
      touch_flag <= 1'b0;
      o_touch_irq <= 1'b0;
    end else if (i_ce) begin
      if (active_mode == `MODE_STANDBY && touch_sync) begin // [R14]
        if (deglitch_cnt < DEGLITCH_TOP) begin
          deglitch_cnt <= deglitch_cnt + 32'h1;
        end
      end else begin
        deglitch_cnt <= 32'h0; // [R16]
      end
      // Set wins over a clear by reading the config register
      if (active_mode == `MODE_STANDBY
          && deglitch_cnt == DEGLITCH_LAST) begin
        touch_flag <= 1'b1; // [R15]
      end else if (i_rd_en && i_addr == `CONVERTER_CONFIG_ADDR) begin
        touch_flag <= 1'b0;
      end
      o_touch_irq <= touch_flag && converter_config[`CFG_IRQ_UNMASK_BIT]; // [R15]
    end
  end
endmodule

// File: logic/touch_pin_sync.v
// Two flip-flop synchroniser for one asynchronous level
module touch_pin_sync (
  input wire i_mclk,
  input wire i_rst,
  input wire i_ce,
  input wire i_async,
  output reg o_sync
);
  reg stage_one;
  // ********************
  // Synchroniser
  // ********************
  // First stage is read only by the second stage
  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      stage_one <= 1'b0;
      o_sync <= 1'b0;
    end else if (i_ce) begin
      stage_one <= i_async;
      o_sync <= stage_one;
    end
  end
endmodule

// File: sim/resistive_touch_mode_sequencer_tb_top.sv
// Register level testbench for the touch mode sequencer
module resistive_touch_mode_sequencer_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic i_mclk, i_rst, i_wr_en, i_rd_en, touched, sense, pref, cref, irq, ce, ca, cb;
  logic [7:0] i_addr, i_wdata, o_rdata;
  logic [3:0] sel, mux;
  logic [1:0] xa, xb, ya, yb;
  int mismatches = 0, checks = 0, cyc = 0;
  localparam logic [7:0] pat [8] = '{8'h6f, 8'hf6, 8'h5a, 8'h60, 8'h06, 8'hfa, 8'hff, 8'h00};
  // Expected transfer gates per mode: channel a in bit 1, channel b in bit 0
  localparam logic [1:0] gate [8] = '{2'h3, 2'h3, 2'h0, 2'h2, 2'h2, 2'h3, 2'h3, 2'h0};
  touch_mode_sequencer dut (.i_mclk(i_mclk), .i_rst(i_rst), .i_ce(ce), .i_wr_en(i_wr_en),
    .i_rd_en(i_rd_en), .i_addr(i_addr), .i_wdata(i_wdata), .i_touch_sense(sense),
    .i_converter_select(sel), .o_rdata(o_rdata), .o_x_plate_a(xa), .o_x_plate_b(xb),
    .o_y_plate_a(ya), .o_y_plate_b(yb), .o_panel_drive_reference(pref),
    .o_converter_reference(cref), .o_panel_channel_a(ca), .o_panel_channel_b(cb),
    .o_converter_mux(mux), .o_touch_irq(irq));
  touch_panel_model panel (.i_x_plate_a(xa), .i_x_plate_b(xb), .i_y_plate_a(ya),
    .i_y_plate_b(yb), .i_touched(touched), .o_touch_sense(sense));
  // ********************
  // Tasks
  // ********************
  task automatic cmp(input string n, input logic [7:0] e, input logic [7:0] s);
    checks++;
    if (s !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input int w);
    @(posedge i_mclk);
    i_addr <= a;
    i_wdata <= d;
    i_wr_en <= 1'b1;
    @(posedge i_mclk);
    i_wr_en <= 1'b0;
    repeat (w) @(posedge i_mclk);
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge i_mclk);
    i_addr <= a;
    i_rd_en <= 1'b1;
    @(posedge i_mclk);
    i_rd_en <= 1'b0;
    @(posedge i_mclk);
    #1 cmp("rdata", e, o_rdata);
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Clock and hang guard
  initial begin
    i_mclk = 1'b0;
    forever #2.5 i_mclk = ~i_mclk;
  end
  always @(posedge i_mclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      mismatches++;
      print_verdict;
    end
  end
  // Main sequence
  initial begin
    i_rst = 1'b1;
    ce = 1'b1;
    i_wr_en = 1'b0;
    i_rd_en = 1'b0;
    i_addr = 8'h00;
    i_wdata = 8'h00;
    sel = 4'h0;
    touched = 1'b0;
    repeat (16) @(posedge i_mclk);
    i_rst <= 1'b0;
    cmp("plates", 8'h00, {xa, xb, ya, yb});
    rd(8'h08, 8'h07);
    rd(8'h09, 8'h00);
    rd(8'h33, 8'h00);
    cmp("cref", 8'h00, {7'h00, cref});
    wr(8'h09, 8'h02, 10);
    cmp("cref", 8'h01, {7'h00, cref});
    wr(8'h09, 8'h04, 10);
    touched <= 1'b1;
    for (int m = 0; m < 8; m++) begin
      wr(8'h08, {5'h1f, m[2:0]}, 10);
      cmp("plates", pat[m], {xa, xb, ya, yb});
      cmp("gates", {6'h00, gate[m]}, {6'h00, ca, cb});
      cmp("cref", {7'h00, m != 7}, {7'h00, cref});
      if (m != 6) cmp("pref", {7'h00, m < 5}, {7'h00, pref});
      cmp("irq", 8'h00, {7'h00, irq});
      rd(8'h08, {5'h00, m[2:0]});
    end
    rd(8'h09, 8'h04);
    wr(8'h33, 8'hff, 10);
    rd(8'h08, 8'h07);
    wr(8'h08, 8'h00, 0);
    wr(8'h08, 8'h04, 10);
    cmp("plates", pat[4], {xa, xb, ya, yb});
    // Clock enable low freezes the block: a write must be lost
    @(posedge i_mclk);
    ce <= 1'b0;
    wr(8'h08, 8'h05, 10);
    cmp("plates", pat[4], {xa, xb, ya, yb});
    @(posedge i_mclk);
    ce <= 1'b1;
    rd(8'h08, 8'h04);
    @(posedge i_mclk);
    sel <= 4'he;
    repeat (3) @(posedge i_mclk);
    #1 cmp("mux", 8'h0e, {4'h0, mux});
    print_verdict;
  end
endmodule

// File: sim/touch_panel_model.sv
// Behavioural four-wire panel that drives the touch comparator
module touch_panel_model (
  input wire logic [1:0] i_x_plate_a,
  input wire logic [1:0] i_x_plate_b,
  input wire logic [1:0] i_y_plate_a,
  input wire logic [1:0] i_y_plate_b,
  input wire logic i_touched,
  output logic o_touch_sense
);
  timeunit 1ns;
  timeprecision 100ps;
  // Comparator trips only while the standby bias is on the plates
  assign o_touch_sense = i_touched && i_x_plate_a == 2'h3 && i_x_plate_b == 2'h3
    && i_y_plate_a == 2'h2 && i_y_plate_b == 2'h2;
endmodule

// File: sim/touch_sequencer_monitor.sv
// Port checker for the touch mode sequencer
module touch_sequencer_monitor (
  input wire i_mclk,
  input wire i_rst,
  input wire i_ce,
  input wire i_wr_en,
  input wire [7:0] i_addr,
  input wire [7:0] i_wdata,
  input wire [3:0] i_converter_select,
  input wire [1:0] o_x_plate_a,
  input wire [1:0] o_x_plate_b,
  input wire [1:0] o_y_plate_a,
  input wire [1:0] o_y_plate_b,
  input wire o_panel_drive_reference,
  input wire o_converter_reference,
  input wire [3:0] o_converter_mux,
  input wire o_touch_irq
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  wire [7:0] pl = {o_x_plate_a, o_x_plate_b, o_y_plate_a, o_y_plate_b};
  reg [2:0] mode_w;
  reg [2:0] cfg_w;
  // Shadow of the last written mode and config bits
  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      mode_w <= 3'h7;
      cfg_w <= 3'h0;
    end else if (i_ce && i_wr_en && i_addr == 8'h08) begin
      mode_w <= i_wdata[2:0];
    end else if (i_ce && i_wr_en && i_addr == 8'h09) begin
      cfg_w <= i_wdata[2:0];
    end
  end
  wire ref_need = cfg_w[0] || cfg_w[1] || mode_w != 3'h7;
  // ********************
  // Assertions
  // ********************
  sequence off_wr;
    i_ce && i_wr_en && i_addr == 8'h08 && i_wdata[2:0] == 3'h7;
  endsequence
  chk_break_first: assert property ($changed(pl) && pl != 8'h00 |-> $past(pl) == 8'h00)
    else $error("plates changed without opening");
  chk_off_open: assert property (off_wr |-> ##9 pl == 8'h00)
    else $error("off mode left a plate connected");
  chk_irq_masked: assert property (!cfg_w[2] && !$past(cfg_w[2]) |-> !o_touch_irq)
    else $error("irq while masked");
  chk_cref_on: assert property (ref_need [*8] |-> o_converter_reference)
    else $error("converter reference off");
  chk_cref_off: assert property (!ref_need [*8] |-> !o_converter_reference)
    else $error("converter reference on");
  chk_standby_ref: assert property (pl == 8'hfa |-> !o_panel_drive_reference)
    else $error("panel reference on in standby");
  chk_measure_ref: assert property (pl inside {8'h6f, 8'hf6, 8'h5a, 8'h60, 8'h06}
    |-> o_panel_drive_reference)
    else $error("panel reference off while measuring");
  chk_mux_copy: assert property ($past(i_ce && !i_rst) |->
    o_converter_mux == $past(i_converter_select))
    else $error("converter mux not following request");
endmodule
bind touch_mode_sequencer touch_sequencer_monitor mon (.i_mclk, .i_rst, .i_ce, .i_wr_en,
  .i_addr, .i_wdata, .i_converter_select, .o_x_plate_a, .o_x_plate_b, .o_y_plate_a,
  .o_y_plate_b, .o_panel_drive_reference, .o_converter_reference, .o_converter_mux,
  .o_touch_irq);
